// ==== logic/sense_defines.vh ====
// constants for the current sense track and hold status block
`ifndef SENSE_DEFINES_VH
`define SENSE_DEFINES_VH
`define SEL_CH0 2'h1
`define SEL_CH1 2'h2
`define SEL_TEMP 2'h3
`define SEL_NONE 2'h0
`define OFFSET_SIGN_BIT 8
`define PREWARN_BIT 8
`define ON_STATE0_BIT 0
`define ON_STATE1_BIT 1
`define SETTLE_TIME_NS 1000
`define CLK_PERIOD_NS 50
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_W 12
`define ST_IDLE 2'h0
`define ST_SETTLE 2'h1
`define ST_VALID 2'h2
`define ST_HOLD 2'h3
`endif

// ==== logic/sense_channel_track.v ====
// per-channel on-state edge tracking
`timescale 1ns/1ns
`include "sense_defines.vh"
module sense_channel_track (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire output_above_half,
  output reg on_state_reg,
  output wire turn_on,
  output wire turn_off
);
  ////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_state_reg <= 1'b0;
    end else if (ce) begin
      on_state_reg <= output_above_half;
    end
  end
  assign turn_on = ce & output_above_half & ~on_state_reg;
  assign turn_off = ce & ~output_above_half & on_state_reg;
endmodule // sense_channel_track

// ==== logic/current_sense_track_hold_status.v ====
// current sense track and hold control with status bits
`timescale 1ns/1ns
`include "sense_defines.vh"
module current_sense_track_hold_status (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire track_hold_enable,
  input wire [1:0] sense_select,
  input wire offset_sign_select_ch0,
  input wire offset_sign_select_ch1,
  input wire [1:0] output_above_half,
  input wire [1:0] channel_drive_command,
  input wire [1:0] overcurrent_window,
  input wire [`SAMPLE_W-1:0] load_current_ch0,
  input wire [`SAMPLE_W-1:0] load_current_ch1,
  input wire [`SAMPLE_W-1:0] random_offset,
  input wire [`SAMPLE_W-1:0] temperature_value,
  input wire temp_above_prewarning,
  input wire normal_mode,
  input wire fault_status_read,
  output reg [`SAMPLE_W-1:0] current_sense_output,
  output reg sense_enabled,
  output reg sense_valid_strobe_n,
  output reg overtemp_prewarning_flag,
  output reg [1:0] channel_on_state,
  output reg [1:0] drive_mismatch
);
  ////////////////////////////////////////////////////////////////
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_i_b;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_i_b = rst_sync_reg;
  ////////////////////////////////////////////////////////////////
  wire [1:0] on_now;
  wire [1:0] rise;
  wire [1:0] fall;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      sense_channel_track u_track (
        .clk(ref_clk),
        .rst_b(rst_i_b),
        .ce(clk_en),
        .output_above_half(output_above_half[g]),
        .on_state_reg(on_now[g]),
        .turn_on(rise[g]),
        .turn_off(fall[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  // sense path selection and offset sign
  reg [1:0] sel_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] settle_reg;
  reg [7:0] settle_next;
  reg [`SAMPLE_W-1:0] hold_reg;
  reg [`SAMPLE_W-1:0] hold_next;
  reg [`SAMPLE_W-1:0] live;
  reg [`SAMPLE_W-1:0] out_next;
  reg ch_on;
  reg ch_rise;
  reg ch_fall;
  reg ch_oc;
  reg sign;
  reg strobe_next;
  wire sel_change;
  wire is_ch;
  assign sel_change = (sense_select != sel_reg);
  assign is_ch = (sense_select == `SEL_CH0) || (sense_select == `SEL_CH1);
  always @* begin
    ch_on = 1'b0;
    ch_rise = 1'b0;
    ch_fall = 1'b0;
    ch_oc = 1'b0;
    sign = 1'b0;
    live = {`SAMPLE_W{1'b0}};
    case (sense_select)
      `SEL_CH0: begin
        ch_on = output_above_half[0];
        ch_rise = rise[0];
        ch_fall = fall[0];
        ch_oc = overcurrent_window[0];
        sign = offset_sign_select_ch0;
        live = load_current_ch0;
      end
      `SEL_CH1: begin
        ch_on = output_above_half[1];
        ch_rise = rise[1];
        ch_fall = fall[1];
        ch_oc = overcurrent_window[1];
        sign = offset_sign_select_ch1;
        live = load_current_ch1;
      end
      `SEL_TEMP: begin
        live = temperature_value;
      end
      default: begin
        live = {`SAMPLE_W{1'b0}};
      end
    endcase
    // offset sign term
    // offset belongs to the current mirror only, temperature passes untouched
    if (is_ch && sign) begin
      live = live + random_offset;
    end else if (is_ch) begin
      live = live - random_offset;
    end
  end
  ////////////////////////////////////////////////////////////////
  // strobe and hold sequencing
  always @* begin
    state_next = state_reg;
    settle_next = settle_reg;
    hold_next = hold_reg;
    strobe_next = 1'b1;
    out_next = {`SAMPLE_W{1'b0}};
    if (!is_ch) begin
      state_next = `ST_IDLE;
      out_next = live;
    end else if (sel_change) begin
      hold_next = {`SAMPLE_W{1'b0}};
      state_next = ch_on ? `ST_SETTLE : `ST_IDLE;
      settle_next = 8'h00;
    end else if (ch_oc) begin
      state_next = ch_on ? `ST_SETTLE : state_reg;
      settle_next = 8'h00;
    end else begin
      case (state_reg)
        `ST_IDLE: begin
          if (ch_rise) begin
            state_next = `ST_SETTLE;
            settle_next = 8'h00;
          end
        end
        `ST_SETTLE: begin
          out_next = live;
          if (ch_fall) begin
            state_next = track_hold_enable ? `ST_HOLD : `ST_IDLE;
            hold_next = live;
          end else if (settle_reg == (`SETTLE_CYCLES - 1)) begin
            state_next = `ST_VALID;
          end else begin
            settle_next = settle_reg + 8'h01;
          end
        end
        `ST_VALID: begin
          strobe_next = 1'b0;
          out_next = live;
          if (ch_fall) begin
            hold_next = live;
            strobe_next = 1'b1;
            state_next = track_hold_enable ? `ST_HOLD : `ST_IDLE;
          end
        end
        `ST_HOLD: begin
          out_next = hold_reg;
          if (ch_rise) begin
            state_next = `ST_SETTLE;
            settle_next = 8'h00;
          end else if (!track_hold_enable) begin
            // leaving hold mode while off drops the held value
            state_next = `ST_IDLE;
            out_next = {`SAMPLE_W{1'b0}};
          end
        end
        default: begin
          state_next = `ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      sel_reg <= `SEL_NONE;
      state_reg <= `ST_IDLE;
      settle_reg <= 8'h00;
      hold_reg <= {`SAMPLE_W{1'b0}};
      current_sense_output <= {`SAMPLE_W{1'b0}};
      sense_enabled <= 1'b0;
      sense_valid_strobe_n <= 1'b1;
      overtemp_prewarning_flag <= 1'b0;
      channel_on_state <= 2'h0;
      drive_mismatch <= 2'h0;
    end else if (clk_en) begin
      sel_reg <= sense_select;
      state_reg <= state_next;
      settle_reg <= settle_next;
      hold_reg <= hold_next;
      current_sense_output <= out_next;
      sense_enabled <= ~ch_oc;
      sense_valid_strobe_n <= strobe_next;
      if (normal_mode && temp_above_prewarning) begin
        overtemp_prewarning_flag <= 1'b1;
      end else if (fault_status_read) begin
        overtemp_prewarning_flag <= 1'b0;
      end
      channel_on_state <= output_above_half;
      drive_mismatch <= output_above_half ^ channel_drive_command;
    end
  end
endmodule // current_sense_track_hold_status

// ==== test/sense_checker_assertions.sv ====
// checker for the current sense track and hold block
`timescale 1ns/1ns
`include "sense_defines.vh"
module sense_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire track_hold_enable,
  input wire [1:0] sense_select,
  input wire [1:0] output_above_half,
  input wire [1:0] overcurrent_window,
  input wire temp_above_prewarning,
  input wire normal_mode,
  input wire fault_status_read,
  input wire [11:0] current_sense_output,
  input wire sense_enabled,
  input wire sense_valid_strobe_n,
  input wire overtemp_prewarning_flag,
  input wire [1:0] channel_on_state
);
  reg [2:0] rdy_reg;
  reg [5:0] on_reg;
  reg [5:0] off_reg;
  wire rdy = rdy_reg == 3'h4;
  wire sel0 = rdy && clk_en && sense_select == `SEL_CH0 && !overcurrent_window[0];
  // counters saturate so long runs never wrap into the settle window
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_reg <= 3'h0;
      on_reg <= 6'h00;
      off_reg <= 6'h00;
    end else begin
      rdy_reg <= rdy ? rdy_reg : rdy_reg + 3'h1;
      on_reg <= (sel0 && output_above_half[0]) ? on_reg + {5'h00, on_reg != 6'h3f} : 6'h00;
      off_reg <= (sel0 && !output_above_half[0]) ? off_reg + {5'h00, off_reg != 6'h3f} : 6'h00;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_off; $fell(output_above_half[0]) && sel0 && !sense_valid_strobe_n; endsequence
  sequence s_oc; (rdy && sense_select == `SEL_CH0 && overcurrent_window[0]) [*2]; endsequence
  property p_settle; on_reg > 6'h00 && on_reg < 6'h13 |-> sense_valid_strobe_n; endproperty
  property p_valid; on_reg == 6'h1a |-> !sense_valid_strobe_n; endproperty
  property p_offstrb; s_off |-> ##[1:3] sense_valid_strobe_n; endproperty
  property p_hold; off_reg > 6'h04 && $stable(track_hold_enable) |->
    (track_hold_enable ? $stable(current_sense_output) : current_sense_output == 12'h000);
  endproperty
  property p_oc; s_oc |-> sense_valid_strobe_n && !sense_enabled; endproperty
  property p_warn; rdy && normal_mode && temp_above_prewarning |=> overtemp_prewarning_flag;
  endproperty
  property p_clr; rdy && $fell(overtemp_prewarning_flag) |->
    $past(fault_status_read && !temp_above_prewarning); endproperty
  property p_onst; rdy |-> channel_on_state == $past(output_above_half); endproperty
  a_settle: assert property (p_settle) else $error("strobe low early");
  a_valid: assert property (p_valid) else $error("strobe not low");
  a_offstrb: assert property (p_offstrb) else $error("strobe not high");
  a_hold: assert property (p_hold) else $error("off value moved");
  a_oc: assert property (p_oc) else $error("sense during window");
  a_warn: assert property (p_warn) else $error("warn not set");
  a_clr: assert property (p_clr) else $error("warn cleared");
  a_onst: assert property (p_onst) else $error("on state");
endmodule // sense_checker
bind current_sense_track_hold_status sense_checker chk (.*);

// ==== test/host_adc_model.sv ====
// host model that captures sense values and averages a pair
`timescale 1ns/1ns
module host_adc_model (
  input wire ref_clk,
  input wire sense_valid_strobe_n,
  input wire [11:0] current_sense_output,
  output reg [11:0] comp_value
);
  reg strb_reg = 1'b1;
  reg [11:0] last_reg = 12'h000;
  wire [12:0] sum_next;
  initial comp_value = 12'h000;
  assign sum_next = {1'b0, last_reg} + {1'b0, current_sense_output};
  always @(posedge ref_clk) begin
    strb_reg <= sense_valid_strobe_n;
    if (sense_valid_strobe_n && !strb_reg) begin
      last_reg <= current_sense_output;
      comp_value <= sum_next[12:1];
    end
  end
endmodule // host_adc_model

// ==== test/current_sense_track_hold_status_tb_top.sv ====
// self-checking bench for the current sense track and hold block
`timescale 1ns/1ns
`include "sense_defines.vh"
module current_sense_track_hold_status_tb_top;
  reg ref_clk = 0, rst_b = 0, clk_en = 1, track_hold_enable = 0, normal_mode = 1;
  reg offset_sign_select_ch0 = 0, offset_sign_select_ch1 = 1, temp_above_prewarning = 0;
  reg fault_status_read = 0;
  reg [1:0] sense_select = `SEL_CH0, output_above_half = 0, channel_drive_command = 0;
  reg [1:0] overcurrent_window = 0;
  reg [11:0] load_current_ch0 = 0, load_current_ch1 = 0, random_offset = 0, temperature_value = 0;
  reg [11:0] held;
  wire [11:0] current_sense_output, comp_value;
  wire [1:0] channel_on_state, drive_mismatch;
  wire sense_enabled, sense_valid_strobe_n, overtemp_prewarning_flag;
  integer errors = 0, n_tests = 0, seed = 94, i;
  current_sense_track_hold_status dut (.*);
  host_adc_model host (.*);
  always #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  function [11:0] f(input s, input [11:0] ld, input [11:0] off);
    f = s ? ld + off : ld - off;
  endfunction
  task chk(input [63:0] name, input [11:0] seen, input [11:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task end_sim;
    begin
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // on time of 1.5 us keeps switching far above 60 hz
  task meas(input th, input s);
    begin
      track_hold_enable = th;
      offset_sign_select_ch0 = s;
      output_above_half[0] = 1;
      channel_drive_command[0] = 1;
      w(30);
      held = f(s, load_current_ch0, random_offset);
      chk("live", current_sense_output, held);
      output_above_half[0] = 0;
      channel_drive_command[0] = 0;
      w(4);
      chk("hold", current_sense_output, th ? held : 12'h000);
      offset_sign_select_ch0 = ~s;
      w(4);
      chk("keep", current_sense_output, th ? held : 12'h000);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    w(5);
    rst_b = 1;
    w(4);
    for (i = 0; i < 8; i = i + 1) begin
      load_current_ch0 = 12'h400 | ($random(seed) & 12'h3ff);
      random_offset = $random(seed) & 12'h0ff;
      meas(i[0], i[1]);
    end
    // second sample only after an on period with opposite sign
    meas(1, 0);
    meas(1, 1);
    chk("comp", comp_value, load_current_ch0);
    output_above_half[0] = 1;
    w(25);
    overcurrent_window[0] = 1;
    w(3);
    chk("ocen", sense_enabled, 12'h000);
    overcurrent_window[0] = 0;
    sense_select = `SEL_CH1;
    w(4);
    chk("clear", current_sense_output, 12'h000);
    output_above_half = 2'h2;
    load_current_ch1 = $random(seed);
    w(2);
    chk("mism", drive_mismatch, 12'h002);
    w(30);
    chk("ch1", current_sense_output, f(1, load_current_ch1, random_offset));
    temperature_value = $random(seed);
    sense_select = `SEL_TEMP;
    w(3);
    chk("temp", current_sense_output, temperature_value);
    held = temperature_value;
    clk_en = 0;
    temperature_value = ~held;
    w(3);
    chk("freeze", current_sense_output, held);
    clk_en = 1;
    w(3);
    chk("thaw", current_sense_output, ~held);
    temp_above_prewarning = 1;
    fault_status_read = 1;
    w(1);
    fault_status_read = 0;
    temp_above_prewarning = 0;
    w(2);
    chk("sticky", overtemp_prewarning_flag, 12'h001);
    fault_status_read = 1;
    w(1);
    fault_status_read = 0;
    w(2);
    chk("cleared", overtemp_prewarning_flag, 12'h000);
    end_sim;
  end
  initial begin
    #200000;
    errors = errors + 1;
    end_sim;
  end
endmodule // current_sense_track_hold_status_tb_top
